// [once_write_bit.sv]
/*
  a control bit that takes only its first software write after reset.
  assumes a synchronous active-high reset on clk_sys.
*/
`timescale 1ns/100ps
`default_nettype none
module once_write_bit
  import supply_monitor_pkg::*;
#(
  parameter logic RESET_VALUE = 1'b0
) (
  // clock and reset
  input  wire logic clk_sys,
  input  wire logic srst,
  // write strobe and value
  input  wire logic wrEn,
  input  wire logic wrData,
  // stored value
  output logic      value
);

  logic written_r;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      value     <= RESET_VALUE;
      written_r <= 1'b0;
    end else if (wrEn && !written_r) begin
      // later writes are dropped until the next reset
      value     <= wrData;
      written_r <= 1'b1;
    end
  end

endmodule
`default_nettype wire

// [supply_monitor_control.sv]
/*
  supply monitor status/control register with axi4-lite access.
  assumes analog comparator outputs already synchronous to clk_sys.
*/
`timescale 1ns/100ps
`default_nettype none
module supply_monitor_control
  import supply_monitor_pkg::*;
(
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        srst,
  // axi4-lite write address
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // axi4-lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read address
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // axi4-lite read data
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // analog side
  input  wire logic        lowSupplyWarning,
  input  wire logic        lowSupplyDetect,
  input  wire logic        stopMode,
  input  wire logic        backgroundDebugEnable,
  // control outputs
  output logic             detectorActive,
  output logic             detectResetReq,
  output logic             warnIrq,
  output logic             bandgapBufferOn,
  output logic             bandgapBufferDriveSelect,
  // event interrupt
  output logic             irq
);

  logic [3:0]      awAddr_r;
  logic            awHave_r;
  logic [31:0]     wData_r;
  logic            wByte0_r;
  logic            wHave_r;
  logic            doWrite;
  logic            writeCtrl;
  logic [7:0]      ctrlRead;
  logic            warnFlag_r;
  logic            warnIe_r;
  logic            detStopEn_r;
  logic            bgDrive_r;
  logic            bgOn_r;
  logic            detRstEn;
  logic            detEn;
  logic            warnPrev_r;
  logic            detPrev_r;
  logic [EV_W-1:0] evStatus_r;
  logic [EV_W-1:0] evEnable_r;
  logic [EV_W-1:0] evSet;
  logic [EV_W-1:0] evClr;
  logic            ackClears;
  logic            detActNxt;
  logic [3:0]      rstCnt_r;

  function automatic logic isAddr(input logic [3:0] a,
                                  input logic [3:0] target);
    return a[3:2] == target[3:2];
  endfunction

  // write channel: address and data latched in either order
  assign doWrite   = awHave_r && wHave_r && !s_axi_bvalid;
  assign writeCtrl = doWrite && wByte0_r && isAddr(awAddr_r, ADDR_CTRL);

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      awHave_r <= 1'b0;
      awAddr_r <= 4'h0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      awHave_r <= 1'b1;
      awAddr_r <= s_axi_awaddr;
    end else if (doWrite) begin
      awHave_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      wHave_r  <= 1'b0;
      wData_r  <= 32'h0000_0000;
      wByte0_r <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      wHave_r  <= 1'b1;
      wData_r  <= s_axi_wdata;
      wByte0_r <= s_axi_wstrb[0];
    end else if (doWrite) begin
      wHave_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
    end else begin
      // one-cycle ready pulses; no new item until the response has gone
      s_axi_awready <= !awHave_r && !s_axi_awready && !s_axi_bvalid
                       && s_axi_awvalid;
      s_axi_wready  <= !wHave_r && !s_axi_wready && !s_axi_bvalid
                       && s_axi_wvalid;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (doWrite) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (isAddr(awAddr_r, ADDR_STATUS)) ? RESP_SLVERR
                                                      : RESP_OKAY;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // free read/write control bits
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      warnIe_r    <= CTRL_RESET[BIT_WARN_IE];
      detStopEn_r <= CTRL_RESET[BIT_DET_STOP_EN];
      bgDrive_r   <= CTRL_RESET[BIT_BG_DRIVE];
      bgOn_r      <= CTRL_RESET[BIT_BG_ON];
    end else if (writeCtrl) begin
      warnIe_r    <= wData_r[BIT_WARN_IE];
      detStopEn_r <= wData_r[BIT_DET_STOP_EN]; // see [RULE8]
      bgDrive_r   <= wData_r[BIT_BG_DRIVE];
      bgOn_r      <= wData_r[BIT_BG_ON];
    end
  end

  // write-once bits
  once_write_bit #(
    .RESET_VALUE (CTRL_RESET[BIT_DET_RST_EN])
  ) u_rstEn (
    .clk_sys (clk_sys),
    .srst    (srst),
    .wrEn    (writeCtrl), // see [RULE7]
    .wrData  (wData_r[BIT_DET_RST_EN]),
    .value   (detRstEn)
  );

  once_write_bit #(
    .RESET_VALUE (CTRL_RESET[BIT_DET_EN])
  ) u_detEn (
    .clk_sys (clk_sys),
    .srst    (srst),
    .wrEn    (writeCtrl), // see [RULE10]
    .wrData  (wData_r[BIT_DET_EN]),
    .value   (detEn)
  );

  // acknowledge is a pulse, not stored; flag writes are ignored
  assign ackClears = writeCtrl && wData_r[BIT_WARN_ACK]
                     && !lowSupplyWarning; // see [RULE3] [RULE15]

  // level set covers a supply already low after reset
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      warnFlag_r <= 1'b0;
    end else if (lowSupplyWarning) begin
      warnFlag_r <= 1'b1; // see [RULE1] [RULE2]
    end else if (ackClears) begin
      warnFlag_r <= 1'b0; // see [RULE14]
    end
  end

  // detection off in stop unless stop-enable or debug keeps it alive
  assign detActNxt = detEn && (!stopMode || detStopEn_r
                     || backgroundDebugEnable); // see [RULE9] [RULE13]

  // reset request stretched so the reset generator cannot miss it
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      rstCnt_r <= 4'h0;
    end else if (detActNxt && detRstEn && lowSupplyDetect) begin
      rstCnt_r <= 4'(RST_PULSE_CYCLES); // see [RULE6]
    end else if (rstCnt_r != 4'h0) begin
      rstCnt_r <= rstCnt_r - 4'h1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      detectorActive           <= 1'b0;
      detectResetReq           <= 1'b0;
      warnIrq                  <= 1'b0;
      bandgapBufferOn          <= 1'b0;
      bandgapBufferDriveSelect <= 1'b0;
    end else begin
      detectorActive           <= detActNxt;
      detectResetReq           <= (rstCnt_r != 4'h0);
      warnIrq                  <= warnIe_r && warnFlag_r; // see [RULE5]
      bandgapBufferOn          <= bgOn_r; // see [RULE12]
      // drive mode only matters while the buffer is on
      bandgapBufferDriveSelect <= bgOn_r && bgDrive_r; // see [RULE11]
    end
  end

  // sticky event bits: rising edges of warning, and of detect while detection is active
  assign evSet = {lowSupplyDetect && !detPrev_r && detActNxt,
                  lowSupplyWarning && !warnPrev_r};
  assign evClr = (doWrite && wByte0_r && isAddr(awAddr_r, ADDR_CLEAR))
                 ? wData_r[EV_W-1:0] : '0;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      warnPrev_r <= 1'b0;
      detPrev_r  <= 1'b0;
    end else begin
      warnPrev_r <= lowSupplyWarning;
      detPrev_r  <= lowSupplyDetect;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      evStatus_r <= '0;
    end else begin
      // set wins over a clear in the same cycle
      evStatus_r <= (evStatus_r & ~evClr) | evSet;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      evEnable_r <= '0;
    end else if (doWrite && wByte0_r && isAddr(awAddr_r, ADDR_ENABLE)) begin
      evEnable_r <= wData_r[EV_W-1:0];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(evStatus_r & evEnable_r);
    end
  end

  // read channel
  assign ctrlRead = {warnFlag_r, 1'b0, warnIe_r, detRstEn, detStopEn_r,
                     detEn, bgDrive_r, bgOn_r};

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      s_axi_arready <= 1'b0;
    end else begin
      s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= RESP_OKAY;
      if (isAddr(s_axi_araddr, ADDR_CTRL)) begin
        s_axi_rdata <= {24'h00_0000, ctrlRead};
      end else if (isAddr(s_axi_araddr, ADDR_STATUS)) begin
        s_axi_rdata <= {30'h0000_0000, evStatus_r};
      end else if (isAddr(s_axi_araddr, ADDR_ENABLE)) begin
        s_axi_rdata <= {30'h0000_0000, evEnable_r};
      end else begin
        // clear register is write-only and reads zero
        s_axi_rdata <= 32'h0000_0000;
      end
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// [supply_monitor_monitor.sv]
/*
  concurrent checks for supply_monitor_control, bound to it.
  assumes only the ports of that module are visible.
*/
`timescale 1ns/100ps
`default_nettype none
module supply_monitor_monitor (
  // clock and reset
  input wire logic        clk_sys,
  input wire logic        srst,
  // bus answers
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // supply side
  input wire logic        lowSupplyWarning,
  input wire logic        lowSupplyDetect,
  input wire logic        detectResetReq,
  input wire logic        warnIrq,
  input wire logic        bandgapBufferOn,
  input wire logic        bandgapBufferDriveSelect,
  input wire logic        irq
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (srst);

  ack_zero_a:
    assert property (s_axi_rvalid |-> !s_axi_rdata[6])
    else $error("ack bit read back as one");
  drive_gate_a:
    assert property (bandgapBufferDriveSelect |-> bandgapBufferOn)
    else $error("drive select without buffer on");
  detect_cause_a:
    assert property ($rose(detectResetReq) |-> $past(lowSupplyDetect)
      || $past(lowSupplyDetect, 2) || $past(lowSupplyDetect, 3))
    else $error("reset request without detect");
  reset_len_a:
    assert property ($rose(detectResetReq) |-> detectResetReq[*5])
    else $error("reset request shorter than five cycles");
  // a write of the enable may drop it, so allow that moment
  irq_hold_a:
    assert property (warnIrq && lowSupplyWarning |=> warnIrq
      || s_axi_bvalid || $past(s_axi_bvalid))
    else $error("warning irq dropped while warning present");
  irq_cause_a:
    assert property ($rose(warnIrq) |-> $past(lowSupplyWarning, 2)
      || $past(s_axi_bvalid) || s_axi_bvalid)
    else $error("warning irq rose without cause");
  write_done_a:
    assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response not retired");
  read_done_a:
    assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read response not retired");

  cover property ($rose(warnIrq));
  cover property ($rose(detectResetReq));
  cover property ($rose(irq));
endmodule

bind supply_monitor_control supply_monitor_monitor mon (
  .clk_sys(clk_sys), .srst(srst),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .lowSupplyWarning(lowSupplyWarning),
  .lowSupplyDetect(lowSupplyDetect), .detectResetReq(detectResetReq),
  .warnIrq(warnIrq), .bandgapBufferOn(bandgapBufferOn),
  .bandgapBufferDriveSelect(bandgapBufferDriveSelect), .irq(irq)
);
`default_nettype wire

// [supply_monitor_pkg.sv]
/*
  constants for the supply monitor status/control block.
  assumes a 32-bit axi4-lite slave and a 50 MHz system clock.
*/
// Behaviour
// [RULE1] set warning flag on supply falling below warning level, or after reset
// [RULE2] warning flag reads 0 with no warning, 1 if present or unacknowledged
// [RULE3] writing 1 to acknowledge bit 6 clears flag only if warning gone
// [RULE4] software clears flag by acknowledge before setting interrupt enable
// [RULE5] interrupt enable bit 5 requests interrupt while warning flag is 1
// [RULE6] reset-on-detect bit 4 with detector on forces reset on detect event
// [RULE7] reset-on-detect bit accepts only its first write after each reset
// [RULE8] stop-enable bit 3 read/write keeps detection running in stop mode
// [RULE9] detector enable bit 2 turns detect logic on and gates other bits
// [RULE10] detector enable accepts only its first write after each reset
// [RULE11] drive-select bit 1 picks low/high buffer drive while buffer enabled
// [RULE12] buffer enable bit 0 turns on bandgap buffer for the adc channel
// [RULE13] detection off in stop mode unless stop-enable or debug enabled
// [RULE14] warning flag read-only; writes to its position change nothing
// [RULE15] acknowledge bit acts only on write of 1, reads back 0
package supply_monitor_pkg;

  localparam logic [3:0] ADDR_CTRL   = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h4;
  localparam logic [3:0] ADDR_ENABLE = 4'h8;
  localparam logic [3:0] ADDR_CLEAR  = 4'hC;

  localparam int BIT_WARN_FLAG   = 7;
  localparam int BIT_WARN_ACK    = 6;
  localparam int BIT_WARN_IE     = 5;
  localparam int BIT_DET_RST_EN  = 4;
  localparam int BIT_DET_STOP_EN = 3;
  localparam int BIT_DET_EN      = 2;
  localparam int BIT_BG_DRIVE    = 1;
  localparam int BIT_BG_ON       = 0;

  // event status bits
  localparam int EV_WARN   = 0;
  localparam int EV_DETECT = 1;
  localparam int EV_W      = 2;

  // control reset value: detector, stop-enable and reset-enable set
  localparam logic [7:0] CTRL_RESET = 8'h1C;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // reset request pulse held for a few cycles
  localparam int RST_PULSE_NS     = 100;
  localparam int CLK_PERIOD_NS    = 20;
  localparam int RST_PULSE_CYCLES = RST_PULSE_NS / CLK_PERIOD_NS;

endpackage

// [test_supply_monitor_control.sv]
/*
  self-checking bench for supply_monitor_control.
  assumes the package and the bound checker are compiled first.
*/
`timescale 1ns/100ps
`default_nettype none
module test_supply_monitor_control import supply_monitor_pkg::*;;
  logic clk_sys = 1'b0, srst = 1'b1;
  logic [3:0] awAddr = 4'h0, arAddr = 4'h0, wStrb = 4'hF;
  logic [31:0] wData = 32'h0000_0000;
  logic awValid = 1'b0, wValid = 1'b0, bReady = 1'b0;
  logic arValid = 1'b0, rReady = 1'b0;
  logic warn = 1'b0, det = 1'b0, stop = 1'b0, dbg = 1'b0;
  logic awRdy, wRdy, bValid, arRdy, rValid, rstReq;
  logic detAct, wIrq, bgOn, bgDrv, irq;
  logic [1:0] bResp, rResp;
  logic [31:0] rData;
  int nMismatch = 0;
  int testsRun = 0;

  always #10 clk_sys = ~clk_sys;

  supply_monitor_control dut (
    .clk_sys(clk_sys), .srst(srst),
    .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid), .s_axi_awready(awRdy),
    .s_axi_wdata(wData), .s_axi_wstrb(wStrb), .s_axi_wvalid(wValid),
    .s_axi_wready(wRdy), .s_axi_bresp(bResp), .s_axi_bvalid(bValid),
    .s_axi_bready(bReady), .s_axi_araddr(arAddr), .s_axi_arvalid(arValid),
    .s_axi_arready(arRdy), .s_axi_rdata(rData), .s_axi_rresp(rResp),
    .s_axi_rvalid(rValid), .s_axi_rready(rReady),
    .lowSupplyWarning(warn), .lowSupplyDetect(det), .stopMode(stop),
    .backgroundDebugEnable(dbg), .detectorActive(detAct),
    .detectResetReq(rstReq), .warnIrq(wIrq), .bandgapBufferOn(bgOn),
    .bandgapBufferDriveSelect(bgDrv), .irq(irq)
  );

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  task automatic chk(input string s, input logic [31:0] e,
                     input logic [31:0] g);
    testsRun++;
    if (g !== e) begin
      nMismatch++;
      $display("MISMATCH %s expected %h seen %h", s, e, g);
    end
  endtask

  task automatic chkb(input string s, input logic e, input logic g);
    chk(s, {31'h0000_0000, e}, {31'h0000_0000, g});
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d,
                    input logic [3:0] s, input logic [1:0] er);
    awAddr <= a;
    wData <= d;
    wStrb <= s;
    awValid <= 1'b1;
    wValid <= 1'b1;
    bReady <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (awRdy) awValid <= 1'b0;
      if (wRdy) wValid <= 1'b0;
    end while (bValid !== 1'b1);
    chk("bresp", {30'h0000_0000, er}, {30'h0000_0000, bResp});
    bReady <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic wc(input logic [31:0] d);
    wr(ADDR_CTRL, d, 4'hF, RESP_OKAY);
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] e, input string s);
    arAddr <= a;
    arValid <= 1'b1;
    rReady <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (arRdy) arValid <= 1'b0;
    end while (rValid !== 1'b1);
    chk(s, e, rData);
    chk("rresp", 32'h0000_0000, {30'h0000_0000, rResp});
    rReady <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic stopTest;
    $display("checks %0d mismatches %0d", testsRun, nMismatch);
    if (nMismatch == 0 && testsRun > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // strobe-less write must not use up the write-once bits
  task automatic tOnce;
    rd(ADDR_CTRL, 32'h0000_001C, "ctrl");
    wr(ADDR_CTRL, 32'h0000_0000, 4'h0, RESP_OKAY);
    wc(32'h0000_005F);
    rd(ADDR_CTRL, 32'h0000_001F, "ctrl");
    chkb("bgDrv", 1'b1, bgDrv);
    wc(32'h0000_0000);
    rd(ADDR_CTRL, 32'h0000_0014, "ctrl");
    chkb("bgOn", 1'b0, bgOn);
    wc(32'h0000_0001);
    chkb("bgOn", 1'b1, bgOn);
    chkb("bgDrv", 1'b0, bgDrv);
  endtask

  task automatic tWarn;
    warn <= 1'b1;
    cyc(3);
    rd(ADDR_CTRL, 32'h0000_0095, "ctrl");
    wc(32'h0000_0055);
    warn <= 1'b0;
    rd(ADDR_CTRL, 32'h0000_0095, "ctrl");
    wc(32'h0000_0055);
    rd(ADDR_CTRL, 32'h0000_0015, "ctrl");
    wc(32'h0000_0095);
    rd(ADDR_CTRL, 32'h0000_0015, "ctrl");
  endtask

  task automatic tIrq;
    // drop the warning event left by the previous scenario
    wr(ADDR_CLEAR, 32'h0000_0003, 4'hF, RESP_OKAY);
    wr(ADDR_ENABLE, 32'h0000_0003, 4'hF, RESP_OKAY);
    chkb("irq", 1'b0, irq);
    wc(32'h0000_0035);
    chkb("warnIrq", 1'b0, wIrq);
    warn <= 1'b1;
    cyc(3);
    chkb("warnIrq", 1'b1, wIrq);
    chkb("irq", 1'b1, irq);
    warn <= 1'b0;
    wc(32'h0000_0075);
    chkb("warnIrq", 1'b0, wIrq);
    wr(ADDR_CLEAR, 32'h0000_0001, 4'hF, RESP_OKAY);
    chkb("irq", 1'b0, irq);
    wr(ADDR_ENABLE, 32'h0000_0000, 4'hF, RESP_OKAY);
    warn <= 1'b1;
    cyc(3);
    chkb("irq", 1'b0, irq);
    rd(ADDR_STATUS, 32'h0000_0001, "status");
    warn <= 1'b0;
    wr(ADDR_CLEAR, 32'h0000_0001, 4'hF, RESP_OKAY);
    wr(ADDR_STATUS, 32'h0000_0003, 4'hF, RESP_SLVERR);
    rd(ADDR_STATUS, 32'h0000_0000, "status");
  endtask

  task automatic tDetStop;
    det <= 1'b1;
    cyc(4);
    chkb("rstReq", 1'b1, rstReq);
    det <= 1'b0;
    cyc(10);
    chkb("rstReq", 1'b0, rstReq);
    rd(ADDR_STATUS, 32'h0000_0002, "status");
    rd(ADDR_CLEAR, 32'h0000_0000, "clear");
    stop <= 1'b1;
    cyc(3);
    chkb("detAct", 1'b0, detAct);
    // detect in stop without stop-enable must not reset
    det <= 1'b1;
    cyc(4);
    chkb("rstReq", 1'b0, rstReq);
    det <= 1'b0;
    dbg <= 1'b1;
    cyc(3);
    chkb("detAct", 1'b1, detAct);
    dbg <= 1'b0;
    wc(32'h0000_003D);
    chkb("detAct", 1'b1, detAct);
    stop <= 1'b0;
  endtask

  // warning held through reset must show in the flag afterwards
  task automatic tReset2;
    warn <= 1'b1;
    srst <= 1'b1;
    cyc(6);
    srst <= 1'b0;
    cyc(1);
    rd(ADDR_CTRL, 32'h0000_009C, "ctrl");
    warn <= 1'b0;
    wc(32'h0000_0040);
    wc(32'h0000_0014);
    rd(ADDR_CTRL, 32'h0000_0000, "ctrl");
    chkb("detAct", 1'b0, detAct);
    det <= 1'b1;
    cyc(4);
    chkb("rstReq", 1'b0, rstReq);
    det <= 1'b0;
  endtask

  initial begin
    cyc(3000);
    nMismatch++;
    stopTest;
  end

  initial begin
    cyc(6);
    srst <= 1'b0;
    cyc(1);
    tOnce;
    tWarn;
    tIrq;
    tDetStop;
    tReset2;
    stopTest;
  end
endmodule
`default_nettype wire
